// file: hw/periodic_timer.sv
// Periodic timer with compare, timer, PWM and single-pulse modes behind AXI4-Lite
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module periodic_timer
    import periodic_timer_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        external_trigger_pin_in,
    output logic             timer_pin_out,
    output logic             timer_pin_oe_out
);
    import periodic_timer_pkg::*;

    logic [7:0]       ctrl0_r, ctrl0_nxt;
    logic [7:0]       ctrl1_r, ctrl1_nxt;
    logic [CNT_W-1:0] cmpa_r, cmpa_nxt;
    logic [CNT_W-1:0] per_r, per_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic             run_q_r, run_q_nxt;
    logic             pin_r, pin_nxt;
    logic             oe_r, oe_nxt;
    logic             flag_a_r, flag_a_nxt;
    logic             flag_p_r, flag_p_nxt;
    logic             aw_got_r, aw_got_nxt;
    logic             w_got_r, w_got_nxt;
    logic [7:0]       waddr_r, waddr_nxt;
    logic [31:0]      wdata_r, wdata_nxt;
    logic             bvalid_r, bvalid_nxt;
    logic [1:0]       bresp_r, bresp_nxt;
    logic             rvalid_r, rvalid_nxt;
    logic [31:0]      rdata_r, rdata_nxt;
    logic [1:0]       rresp_r, rresp_nxt;
    logic             arready_r, arready_nxt;
    logic             tick;
    logic             trig_rise;

    // Timer clock selection comes from the control register as a divided enable
    tick_divider #(
        .SEL_W (CLKSEL_W)
    ) u_div (
        .clk_sys_in (clk_sys_in),
        .resetn_in  (resetn_in),
        .sel_in     (ctrl0_r[CLKSEL_LSB +: CLKSEL_W]),
        .tick_out   (tick)
    );

    pin_sync u_trig (
        .clk_sys_in (clk_sys_in),
        .resetn_in  (resetn_in),
        .pin_in     (external_trigger_pin_in),
        .rise_out   (trig_rise)
    );

    // Decoded control fields
    logic [1:0] mode;
    logic [1:0] pact;
    logic       run, init_lvl, inv, clr_src, single, wr_go;
    assign mode     = {ctrl1_r[MODE_HI_BIT], ctrl1_r[MODE_LO_BIT]};
    assign pact     = {ctrl1_r[PACT_HI_BIT], ctrl1_r[PACT_LO_BIT]};
    assign run      = ctrl0_r[RUN_BIT];
    assign init_lvl = ctrl1_r[INIT_BIT];
    assign inv      = ctrl1_r[INV_BIT];
    assign clr_src  = ctrl1_r[CLRSRC_BIT];
    assign single   = (mode == MODE_PWM) && (pact == PACT_TOGGLE);
    assign wr_go    = aw_got_r && w_got_r && !bvalid_r;

    // Write channel: address and data taken in either order, response after both.
    // Both stay captured until the response is taken, so no new write slips in early.
    always_comb
    begin
        aw_got_nxt = aw_got_r;
        w_got_nxt  = w_got_r;
        waddr_nxt  = waddr_r;
        wdata_nxt  = wdata_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt  = bresp_r;
        if (s_axi_awvalid && !aw_got_r)
        begin
            aw_got_nxt = 1'b1;
            waddr_nxt  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_r)
        begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
        end
        if (wr_go)
        begin
            bvalid_nxt = 1'b1;
            bresp_nxt  = (waddr_r <= STATUS_OFFS && waddr_r[1:0] == 2'h0) ? AXI_OKAY : AXI_SLVERR;
        end
        else if (bvalid_r && s_axi_bready)
        begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b0;
        end
    end

    // Read channel: one read at a time, unmapped addresses answer SLVERR with zero data
    always_comb
    begin
        arready_nxt = !rvalid_r && !arready_r;
        rvalid_nxt  = rvalid_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        if (s_axi_arvalid && arready_r)
        begin
            arready_nxt = 1'b0;
            rvalid_nxt  = 1'b1;
            rresp_nxt   = AXI_OKAY;
            case (s_axi_araddr)
                CTRL0_OFFS:  rdata_nxt = {24'h000000, ctrl0_r};
                CTRL1_OFFS:  rdata_nxt = {24'h000000, ctrl1_r};
                COUNT_OFFS:  rdata_nxt = {22'h000000, cnt_r};
                CMPA_OFFS:   rdata_nxt = {22'h000000, cmpa_r};
                PERIOD_OFFS: rdata_nxt = {22'h000000, per_r};
                STATUS_OFFS: rdata_nxt = {29'h00000000, pin_r, flag_p_r, flag_a_r};
                default:
                begin
                    rdata_nxt = 32'h00000000;
                    rresp_nxt = AXI_SLVERR;
                end
            endcase
        end
        else if (rvalid_r && s_axi_rready)
        begin
            rvalid_nxt = 1'b0;
        end
    end

    // Counter, comparators, flags and pin; register writes merge in here
    logic [CNT_W-1:0] inc;
    logic             m_a, m_p, ovf, run_rise, pwm_act;
    always_comb
    begin
        ctrl0_nxt  = ctrl0_r;
        ctrl1_nxt  = ctrl1_r;
        cmpa_nxt   = cmpa_r;
        per_nxt    = per_r;
        cnt_nxt    = cnt_r;
        pin_nxt    = pin_r;
        // Write-one clears come first; any set below overrides them, so set wins
        flag_a_nxt = flag_a_r && !(wr_go && waddr_r == STATUS_OFFS && wdata_r[FLAG_A_BIT]);
        flag_p_nxt = flag_p_r && !(wr_go && waddr_r == STATUS_OFFS && wdata_r[FLAG_P_BIT]);
        run_q_nxt  = run;
        oe_nxt     = (mode != MODE_TIMER);
        inc        = cnt_r + 10'h001;
        m_a        = 1'b0;
        m_p        = 1'b0;
        ovf        = 1'b0;
        run_rise   = run && !run_q_r;
        pwm_act    = 1'b0;
        if (run_rise)
        begin
            cnt_nxt = VALUE_RST;
            if (mode != MODE_TIMER)
                pin_nxt = init_lvl;
        end
        else if (run && tick)
        begin
            cnt_nxt = inc;
            m_a = (inc == cmpa_r) && (cmpa_r != 10'h000);
            m_p = (inc == per_r) && (per_r != 10'h000);
            ovf = (inc == 10'h000);
            if (mode == MODE_PWM && !single)
            begin
                // Period match or wrap at 1024 when period is zero
                if (m_p || (per_r == 10'h000 && cnt_r == 10'h3FF))
                    cnt_nxt = VALUE_RST;
                if (m_a)
                    flag_a_nxt = 1'b1;
                if (m_p || (per_r == 10'h000 && cnt_r == 10'h3FF))
                    flag_p_nxt = 1'b1;
            end
            else if (single)
            begin
                if (m_a)
                begin
                    flag_a_nxt = 1'b1;
                    ctrl0_nxt[RUN_BIT] = 1'b0;
                end
            end
            else
            begin
                if (m_a)
                begin
                    flag_a_nxt = 1'b1;
                    if (mode == MODE_CMP)
                    begin
                        case (pact)
                            PACT_LOW:    pin_nxt = 1'b0;
                            PACT_HIGH:   pin_nxt = 1'b1;
                            PACT_TOGGLE: pin_nxt = ~pin_r;
                            default:     pin_nxt = pin_r;
                        endcase
                    end
                end
                if (clr_src)
                begin
                    if (m_a)
                        cnt_nxt = VALUE_RST;
                end
                else
                begin
                    if (m_p || ovf)
                        cnt_nxt = VALUE_RST;
                    if (m_p || (per_r == 10'h000 && ovf))
                        flag_p_nxt = 1'b1;
                end
            end
        end
        // PWM and single-pulse pin levels; counter keeps running for 00/01
        if (mode == MODE_PWM)
        begin
            if (single)
                pwm_act = run;
            else if (per_r != 10'h000 && cmpa_r >= per_r)       // Zero period is 1024
                pwm_act = 1'b1;
            else
                pwm_act = (cnt_nxt < cmpa_r);
            case (pact)
                PACT_NONE: pin_nxt = ~init_lvl ^ inv;
                PACT_LOW:  pin_nxt = init_lvl ^ inv;
                default:   pin_nxt = (pwm_act ? init_lvl : ~init_lvl) ^ inv;
            endcase
        end
        else if (mode == MODE_CMP && run_rise)
            pin_nxt = init_lvl ^ 1'b0;
        // Trigger pin starts a pulse only in single-pulse mode
        if (single && trig_rise)
            ctrl0_nxt[RUN_BIT] = 1'b1;
        // Software writes to the control and value registers
        if (wr_go)
        begin
            case (waddr_r)
                CTRL0_OFFS:  if (s_axi_wstrb[0]) ctrl0_nxt = wdata_r[7:0];
                CTRL1_OFFS:  if (s_axi_wstrb[0]) ctrl1_nxt = wdata_r[7:0] & 8'hFD;
                CMPA_OFFS:   cmpa_nxt = wdata_r[CNT_W-1:0];
                PERIOD_OFFS: per_nxt  = wdata_r[CNT_W-1:0];
                default: ;
            endcase
        end
    end

    // All state registers
    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
        begin
            ctrl0_r   <= CTRL0_RST;
            ctrl1_r   <= CTRL1_RST;
            cmpa_r    <= VALUE_RST;
            per_r     <= VALUE_RST;
            cnt_r     <= VALUE_RST;
            run_q_r   <= 1'b0;
            pin_r     <= 1'b0;
            oe_r      <= 1'b0;
            flag_a_r  <= 1'b0;
            flag_p_r  <= 1'b0;
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            waddr_r   <= 8'h00;
            wdata_r   <= 32'h00000000;
            bvalid_r  <= 1'b0;
            bresp_r   <= AXI_OKAY;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h00000000;
            rresp_r   <= AXI_OKAY;
            arready_r <= 1'b0;
        end
        else
        begin
            ctrl0_r   <= ctrl0_nxt;
            ctrl1_r   <= ctrl1_nxt;
            cmpa_r    <= cmpa_nxt;
            per_r     <= per_nxt;
            cnt_r     <= cnt_nxt;
            run_q_r   <= run_q_nxt;
            pin_r     <= pin_nxt;
            oe_r      <= oe_nxt;
            flag_a_r  <= flag_a_nxt;
            flag_p_r  <= flag_p_nxt;
            aw_got_r  <= aw_got_nxt;
            w_got_r   <= w_got_nxt;
            waddr_r   <= waddr_nxt;
            wdata_r   <= wdata_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
            arready_r <= arready_nxt;
        end
    end

    // Ready flags are flop outputs: write readies from the capture registers, read ready from arready_r
    assign s_axi_awready    = !aw_got_r;
    assign s_axi_wready     = !w_got_r;
    assign s_axi_bvalid     = bvalid_r;
    assign s_axi_bresp      = bresp_r;
    assign s_axi_arready    = arready_r;
    assign s_axi_rvalid     = rvalid_r;
    assign s_axi_rdata      = rdata_r;
    assign s_axi_rresp      = rresp_r;
    assign timer_pin_out    = pin_r;
    assign timer_pin_oe_out = oe_r;
endmodule // periodic_timer

// file: hw/periodic_timer_pkg.sv
// Package of register offsets, field positions, reset values and encodings
package periodic_timer_pkg;

    localparam int CNT_W = 10;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] CTRL0_OFFS   = 8'h00;
    localparam logic [7:0] CTRL1_OFFS   = 8'h04;
    localparam logic [7:0] COUNT_OFFS   = 8'h08;
    localparam logic [7:0] CMPA_OFFS    = 8'h0C;
    localparam logic [7:0] PERIOD_OFFS  = 8'h10;
    localparam logic [7:0] STATUS_OFFS  = 8'h14;

    // Control 0 fields: run bit and timer clock divider select
    localparam int RUN_BIT      = 3;
    localparam int CLKSEL_LSB   = 0;
    localparam int CLKSEL_W     = 3;

    // Control 1 fields (timer_control_one)
    localparam int MODE_HI_BIT  = 7;
    localparam int MODE_LO_BIT  = 6;
    localparam int PACT_HI_BIT  = 5;
    localparam int PACT_LO_BIT  = 4;
    localparam int INIT_BIT     = 3;
    localparam int INV_BIT      = 2;
    localparam int CLRSRC_BIT   = 0;

    // Status fields; the two flags are write one to clear, the pin bit is read only
    localparam int FLAG_A_BIT   = 0;
    localparam int FLAG_P_BIT   = 1;
    localparam int PIN_BIT      = 2;

    // Reset values
    localparam logic [7:0]       CTRL0_RST  = 8'h00;
    localparam logic [7:0]       CTRL1_RST  = 8'h00;
    localparam logic [CNT_W-1:0] VALUE_RST  = 10'h000;

    // Mode and pin action encodings
    localparam logic [1:0] MODE_CMP    = 2'h0;
    localparam logic [1:0] MODE_PWM    = 2'h2;
    localparam logic [1:0] MODE_TIMER  = 2'h3;
    localparam logic [1:0] PACT_NONE   = 2'h0;
    localparam logic [1:0] PACT_LOW    = 2'h1;
    localparam logic [1:0] PACT_HIGH   = 2'h2;
    localparam logic [1:0] PACT_TOGGLE = 2'h3;

    localparam logic [1:0] AXI_OKAY    = 2'h0;
    localparam logic [1:0] AXI_SLVERR  = 2'h2;

endpackage

// file: hw/pin_sync.sv
// Three-stage synchroniser with edge detect for the external trigger pin
`timescale 1ns/100ps
module pin_sync (
    input  wire logic clk_sys_in,
    input  wire logic resetn_in,
    input  wire logic pin_in,
    output logic      rise_out
);
    logic [2:0] sync_r;
    logic [2:0] sync_nxt;
    logic       level_r;
    logic       level_nxt;
    logic       rise_r;
    logic       rise_nxt;

    // Level changes only once stages two and three agree; stage one feeds stage two only
    always_comb
    begin
        sync_nxt  = {sync_r[1:0], pin_in};
        level_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : level_r;
        rise_nxt  = level_nxt & ~level_r;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
        begin
            sync_r  <= 3'h0;
            level_r <= 1'b0;
            rise_r  <= 1'b0;
        end
        else
        begin
            sync_r  <= sync_nxt;
            level_r <= level_nxt;
            rise_r  <= rise_nxt;
        end
    end

    assign rise_out = rise_r;
endmodule // pin_sync

// file: hw/tick_divider.sv
// Divider that turns the system clock into a one-cycle timer tick enable
`timescale 1ns/100ps
module tick_divider #(
    parameter int SEL_W = 3
) (
    input  wire logic             clk_sys_in,
    input  wire logic             resetn_in,
    input  wire logic [SEL_W-1:0] sel_in,
    output logic                  tick_out
);
    logic [7:0] div_r;
    logic [7:0] div_nxt;
    logic       tick_r;
    logic       tick_nxt;

    // Tick rate is clk / 2^sel; a free running counter keeps all rates phase related
    always_comb
    begin
        div_nxt  = div_r + 8'h01;
        tick_nxt = (sel_in == '0) ? 1'b1
                 : (div_r[sel_in - 1'b1 -: 1] == 1'b1) &&
                   ((div_r & ((8'h01 << (sel_in - 1'b1)) - 8'h01)) ==
                    ((8'h01 << (sel_in - 1'b1)) - 8'h01));
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
        begin
            div_r  <= 8'h00;
            tick_r <= 1'b0;
        end
        else
        begin
            div_r  <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_out = tick_r;
endmodule // tick_divider

// file: tb/periodic_timer_properties.sv
// Port-level checker for the periodic timer register bus and reset behaviour
`timescale 1ns/100ps
module periodic_timer_properties
    import periodic_timer_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    input  wire logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    input  wire logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    // Reset leaves no answer pending and the write side open
    a_reset_quiet: assert property (disable iff (1'b0)
        !resetn_in |=> !s_axi_bvalid && !s_axi_rvalid && s_axi_awready && s_axi_wready)
        else $error("bus not idle after reset");
    // Each accepted request is answered in time: a write within 1 to 3 cycles, a read the next cycle
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write never answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    // One answer per request; a taken answer must drop
    a_b_one_beat: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_r_one_beat: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    // New requests are refused while an answer is pending
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answer pending");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    // Error reads return zero and registers never fill the upper half
    a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR |->
        s_axi_rdata == 32'h0) else $error("error read returned data");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
        else $error("upper read bits not zero");

    c_err_read: cover property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR);
    c_write_done: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == AXI_OKAY);
    c_read_done: cover property (s_axi_rvalid && s_axi_rready && s_axi_rdata != 32'h0);
endmodule // periodic_timer_properties

bind periodic_timer periodic_timer_properties u_periodic_timer_properties (
    .clk_sys_in, .resetn_in, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// file: tb/test_periodic_timer.sv
// Self-checking bench for the periodic timer: registers, compare, timer, PWM, pulse
`timescale 1ns/100ps
module test_periodic_timer;
    import periodic_timer_pkg::*;
    logic        clk_sys_in = 1'b0;
    logic        resetn_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, fire, pad;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        external_trigger_pin_in, timer_pin_out, timer_pin_oe_out;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, pa;
    logic [65:0] exp_r[$];
    logic [65:0] e;
    logic [1:0]  exp_b[$];
    int          failures = 0, checked = 0, cycles = 0, seed, h;

    periodic_timer u_periodic_timer (.clk_sys_in, .resetn_in, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .external_trigger_pin_in, .timer_pin_out, .timer_pin_oe_out);
    trigger_source u_trigger_source (.clk_sys_in, .fire_in(fire), .timer_pin_in(timer_pin_out),
        .timer_pin_oe_in(timer_pin_oe_out), .trig_out(external_trigger_pin_in), .pad_out(pad));

    always #20 clk_sys_in = ~clk_sys_in;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Write holds each channel until its own ready, then waits for the response
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = AXI_OKAY);
        @(posedge clk_sys_in);
        exp_b.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge clk_sys_in);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    // Read notes the masked expectation for the monitor before issuing
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = '1,
                      input logic [1:0] r = AXI_OKAY);
        @(posedge clk_sys_in);
        exp_r.push_back({r, m, d & m});
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge clk_sys_in);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    task automatic run(input logic on);
        wr(CTRL0_OFFS, {28'h0, on, 3'h0});
    endtask

    // Stop, program values and mode, clear flags, then optionally start
    task automatic go(input logic [1:0] md, p_act, input logic il, iv, cl,
                      input logic [31:0] a, p, input logic rn);
        run(1'b0);
        wr(CMPA_OFFS, a);
        wr(PERIOD_OFFS, p);
        wr(CTRL1_OFFS, {24'h0, md, p_act, il, iv, 1'b0, cl});
        wr(STATUS_OFFS, 32'h3);
        run(rn);
    endtask

    // Count high cycles on the pad over a window
    task automatic hi(input int n);
        h = 0;
        repeat (n)
        begin
            @(posedge clk_sys_in);
            h += (pad === 1'b1);
        end
    endtask

    // PWM window: period-aligned counts make the high total independent of phase
    task automatic pw(input logic [1:0] p_act, input logic il, iv,
                      input logic [31:0] a, p, input int n, want);
        go(MODE_PWM, p_act, il, iv, 1'b1, a, p, 1'b1);
        repeat (12) @(posedge clk_sys_in);
        hi(n);
        check("pwm high cycles", h, want);
    endtask

    // Monitor pairs each answer with the oldest note
    always @(posedge clk_sys_in)
    begin
        if (s_axi_rvalid && s_axi_rready)
        begin
            e = exp_r.pop_front();
            check("rdata", s_axi_rdata & e[63:32], e[31:0]);
            check("rresp", s_axi_rresp, e[65:64]);
        end
        if (s_axi_bvalid && s_axi_bready)
            check("bresp", s_axi_bresp, exp_b.pop_front());
        cycles++;
        if (cycles == 40000)
        begin
            failures++;
            final_report();
        end
    end

    initial
    begin
        seed = 53815;
        {resetn_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 4'h0;
        {s_axi_arvalid, s_axi_rready, fire} <= 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
        s_axi_wstrb <= 4'hF;
        repeat (2) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        rd(CTRL0_OFFS, CTRL0_RST);
        rd(CTRL1_OFFS, CTRL1_RST);
        rd(COUNT_OFFS, VALUE_RST);
        rd(8'h18, 32'h0, '1, AXI_SLVERR);
        wr(8'h18, 32'h1, AXI_SLVERR);
        repeat (4)
        begin
            v = $random(seed);
            wr(CMPA_OFFS, v);
            rd(CMPA_OFFS, v & 32'h3FF);
            wr(PERIOD_OFFS, ~v);
            rd(PERIOD_OFFS, ~v & 32'h3FF);
            wr(CTRL1_OFFS, v);
            rd(CTRL1_OFFS, v & 32'hFD);
        end
        $display("test registers done");
        // Single A match before overflow, so toggle flips exactly once
        for (int i = 0; i < 8; i++)
        begin
            pa = i[1:0];
            go(MODE_CMP, pa, i[2], 1'b0, 1'b0, 40, 0, 1'b1);
            repeat (100) @(posedge clk_sys_in);
            run(1'b0);
            v = {pa == PACT_NONE ? i[2] : pa == PACT_TOGGLE ? !i[2] : pa[1], 2'b01};
            rd(STATUS_OFFS, v);
            wr(STATUS_OFFS, 32'h3);
            run(1'b1);
            rd(STATUS_OFFS, {i[2], 2'b00});
        end
        go(MODE_CMP, PACT_LOW, 1'b1, 1'b0, 1'b0, 30, 10, 1'b1);
        repeat (100) @(posedge clk_sys_in);
        rd(STATUS_OFFS, 3'b110);
        go(MODE_CMP, PACT_LOW, 1'b1, 1'b0, 1'b1, 12, 5, 1'b1);
        repeat (100) @(posedge clk_sys_in);
        rd(STATUS_OFFS, 3'b001);
        // Timer clock divided by four: the A match at 10 must not come within 16 cycles
        go(MODE_CMP, PACT_HIGH, 1'b0, 1'b0, 1'b0, 10, 0, 1'b0);
        wr(CTRL0_OFFS, 32'hA);
        repeat (16) @(posedge clk_sys_in);
        rd(STATUS_OFFS, 3'b000);
        repeat (40) @(posedge clk_sys_in);
        rd(STATUS_OFFS, 3'b101);
        $display("test compare done");
        go(MODE_TIMER, PACT_TOGGLE, 1'b1, 1'b0, 1'b0, 0, 0, 1'b1);
        hi(1100);
        check("timer pad", h, 0);
        check("timer oe", timer_pin_oe_out, 1'b0);
        rd(STATUS_OFFS, 3'b010, 32'h3);
        $display("test timer done");
        pw(PACT_HIGH, 1'b1, 1'b0, 2, 5, 50, 20);
        pw(PACT_HIGH, 1'b1, 1'b0, 8, 5, 50, 50);
        pw(PACT_HIGH, 1'b1, 1'b1, 2, 5, 50, 30);
        pw(PACT_HIGH, 1'b0, 1'b0, 2, 5, 50, 30);
        pw(PACT_HIGH, 1'b1, 1'b0, 512, 0, 2048, 1024);
        pw(PACT_HIGH, 1'b1, 1'b0, 1023, 0, 2048, 2046);
        pw(PACT_LOW, 1'b1, 1'b0, 2, 5, 50, 50);
        pw(PACT_NONE, 1'b1, 1'b0, 2, 5, 50, 0);
        rd(STATUS_OFFS, 3'b011, 32'h3);
        $display("test pwm done");
        // Period 3 would cut the count short if it were not ignored
        go(MODE_PWM, PACT_TOGGLE, 1'b1, 1'b0, 1'b0, 20, 3, 1'b0);
        fire <= 1'b1;
        @(posedge clk_sys_in);
        fire <= 1'b0;
        hi(80);
        check("pulse width", h >= 19 && h <= 21, 1);
        rd(CTRL0_OFFS, 32'h0, 32'h8);
        rd(STATUS_OFFS, 3'b001, 32'h5);
        go(MODE_PWM, PACT_TOGGLE, 1'b1, 1'b0, 1'b0, 300, 0, 1'b1);
        repeat (10) @(posedge clk_sys_in);
        check("pulse lead", pad, 1'b1);
        run(1'b0);
        rd(STATUS_OFFS, 3'b000, 32'h5);
        $display("test pulse done");
        final_report();
    end
endmodule // test_periodic_timer

// file: tb/trigger_source.sv
// Far-side model: trigger pin source and the pulled-down load on the timer pin
`timescale 1ns/100ps
module trigger_source (
    input  wire logic clk_sys_in,
    input  wire logic fire_in,
    input  wire logic timer_pin_in,
    input  wire logic timer_pin_oe_in,
    output logic      trig_out,
    output logic      pad_out
);
    int hold_r = 0;

    // Stretch each trigger so the three-flop synchroniser cannot miss it
    always @(posedge clk_sys_in)
    begin
        if (fire_in)
            hold_r <= 6;
        else if (hold_r > 0)
            hold_r <= hold_r - 1;
        trig_out <= fire_in || hold_r > 1;
    end
    // Pull-down wins when the block releases the pin
    assign pad_out = timer_pin_oe_in ? timer_pin_in : 1'b0;
endmodule // trigger_source
